// >>> rtl/alx_pkg.sv
// Package of constants and carrier types for the arithmetic and logical execution unit
package alx_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [3:0] NATIVE_CLOCKS_RST = 4'h4;  // Clocks per machine cycle at reset
  localparam logic [1:0] WAIT_STATES_RST = 2'h0;
  localparam logic [2:0] CLK_DIV_RST = 3'h0;

  // ****************************************
  // Operation codes seen by this unit
  // ****************************************
  typedef enum logic [4:0] {
    ALX_OP_ADD = 5'h00,
    ALX_OP_ADD_WITH_CARRY = 5'h01,
    ALX_OP_SUBTRACT_WITH_BORROW = 5'h02,
    ALX_OP_AND = 5'h03,
    ALX_OP_OR = 5'h04,
    ALX_OP_XOR = 5'h05,
    ALX_OP_SWAP = 5'h06,
    ALX_OP_RLC = 5'h07,
    ALX_OP_RRC = 5'h08,
    ALX_OP_MUL = 5'h09,
    ALX_OP_DIV = 5'h0a,
    ALX_OP_INC_DP = 5'h0b
  } alx_op_e;

  // Operand forms
  typedef enum logic [2:0] {
    ALX_SRC_REG = 3'h0,   // bank_register
    ALX_SRC_IND = 3'h1,   // pointer_register_indirect
    ALX_SRC_DIR = 3'h2,
    ALX_SRC_IMM = 3'h3,
    ALX_DST_DIR_ACC = 3'h4, // Direct byte destination, accumulator source
    ALX_DST_DIR_IMM = 3'h5  // Direct byte destination, immediate source
  } alx_form_e;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [2:0] MC_ONE = 3'h1;
  localparam logic [2:0] MC_TWO = 3'h2;
  localparam logic [2:0] MC_FOUR = 3'h4;

  // Instruction issued by decode
  typedef struct packed {
    alx_op_e op;
    alx_form_e form;
    logic [7:0] acc;
    logic [7:0] operand;   // Register, indirect, direct or immediate data
    logic [7:0] dir_data;  // Current direct byte for direct destination forms
    logic [7:0] b_reg;
    logic [15:0] data_pointer_16;     // data_pointer_16
  } alx_instr_s;

  // Program status flags
  typedef struct packed {
    logic cy;
    logic ac;
    logic ov;
    logic p;
  } alx_flags_s;

  // Results handed back
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b_reg;
    logic [7:0] dir_data;
    logic dir_we;
    logic [15:0] data_pointer_16;
    alx_flags_s flags;
    logic [1:0] length;
    logic [2:0] mcycles;
  } alx_result_s;

endpackage

// >>> rtl/alx_mcycle_timer.sv
// Machine cycle timer: paces execution in machine-cycle ticks
`timescale 1ns/100ps
`default_nettype none
module alx_mcycle_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Cycle settings
  input wire logic [1:0] wait_states_in,   // bus_wait_control
  input wire logic [2:0] clk_div_in,       // clock_divider_control
  // Stall sources
  input wire logic pfq_stall_in,           // prefetch_queue not ready
  input wire logic bc_miss_in,             // branch_target_cache miss
  // Tick and stretch
  output logic tick_out,
  output logic stretch_out
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
    logic stretch;
  } alx_tmr_s;

  alx_tmr_s st_reg;
  alx_tmr_s st_next;
  logic [7:0] native_len;

  // Native length: base clocks plus wait states, scaled by the divider
  assign native_len = 8'((8'(alx_pkg::NATIVE_CLOCKS_RST) + 8'(wait_states_in)) << clk_div_in);

  // Count down; a stall holds the count at its last clock so the cycle grows
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    st_next.stretch = 1'b0;
    if (st_reg.cnt <= 8'h01) begin
      if (pfq_stall_in || bc_miss_in) begin
        st_next.stretch = 1'b1;
      end else begin
        st_next.tick = 1'b1;
        st_next.cnt = native_len;
      end
    end else begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '{cnt: 8'h04, tick: 1'b0, stretch: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;
  assign stretch_out = st_reg.stretch;

  // No tick while a stall is present at the end of a cycle
  a_stall_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_reg.cnt <= 8'h01 && (pfq_stall_in || bc_miss_in)) |=> !tick_out)
    else $error("Tick issued during stall");
  // Unstalled ticks are spaced exactly native length, checked when native length is 4
  a_native_len: assert property (@(posedge clk_in) disable iff (rst_in)
    (tick_out && !pfq_stall_in && !bc_miss_in && $stable(wait_states_in)
     && $stable(clk_div_in) && native_len == 8'h04) ##1
    (!pfq_stall_in && !bc_miss_in)[*4] |-> tick_out)
    else $error("Native cycle length wrong");

endmodule
`default_nettype wire

// >>> rtl/alx_exec.sv
// Arithmetic and logical execution unit with machine-cycle timing
`timescale 1ns/100ps
`default_nettype none
module alx_exec (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // Cycle settings from core configuration
  input wire logic [1:0] WAIT_STATES_IN,
  input wire logic [2:0] CLK_DIV_IN,
  // Stall sources from fetch
  input wire logic PFQ_STALL_IN,
  input wire logic BC_MISS_IN,
  // Instruction request from decode
  input wire logic ISSUE_IN,
  input wire alx_pkg::alx_instr_s INSTR_IN,
  input wire alx_pkg::alx_flags_s FLAGS_IN,
  // Status and results
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic STRETCH_OUT,
  output alx_pkg::alx_result_s RESULT_OUT
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {
    ALX_IDLE = 3'b001,
    ALX_RUN = 3'b010,
    ALX_DONE = 3'b100
  } alx_state_e;

  typedef struct packed {
    alx_state_e fsm;
    alx_pkg::alx_result_s res;
    alx_pkg::alx_result_s pend;
    logic [2:0] left;
    logic done;
    logic busy;
    logic stretch;
  } alx_core_s;

  alx_core_s st_reg;
  alx_core_s st_next;
  logic tick;
  logic stretch;
  alx_pkg::alx_result_s calc;

  // ****************************************
  // Machine cycle pacing
  // ****************************************
  alx_mcycle_timer u_timer (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .wait_states_in(WAIT_STATES_IN),
    .clk_div_in(CLK_DIV_IN),
    .pfq_stall_in(PFQ_STALL_IN),
    .bc_miss_in(BC_MISS_IN),
    .tick_out(tick),
    .stretch_out(stretch)
  );

  // ****************************************
  // Datapath
  // ****************************************
  // Computes result, flags, length and cycle count for one instruction
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] opnd;
    logic [15:0] prod;
    logic [7:0] src;
    sum = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    src = INSTR_IN.acc;
    opnd = INSTR_IN.operand;
    calc.acc = INSTR_IN.acc;
    calc.b_reg = INSTR_IN.b_reg;
    calc.dir_data = INSTR_IN.dir_data;
    calc.dir_we = 1'b0;
    calc.data_pointer_16 = INSTR_IN.data_pointer_16;
    calc.flags = FLAGS_IN;
    calc.mcycles = alx_pkg::MC_ONE;
    // Register/indirect one byte, direct/immediate two
    calc.length = (INSTR_IN.form == alx_pkg::ALX_SRC_REG ||
                   INSTR_IN.form == alx_pkg::ALX_SRC_IND) ? alx_pkg::LEN_ONE : alx_pkg::LEN_TWO;
    unique case (INSTR_IN.op)
      alx_pkg::ALX_OP_ADD, alx_pkg::ALX_OP_ADD_WITH_CARRY: begin
        // Sum with optional carry in
        sum = 9'(INSTR_IN.acc) + 9'(opnd) +
              9'(INSTR_IN.op == alx_pkg::ALX_OP_ADD_WITH_CARRY && FLAGS_IN.cy);
        nib = 5'(INSTR_IN.acc[3:0]) + 5'(opnd[3:0]) +
              5'(INSTR_IN.op == alx_pkg::ALX_OP_ADD_WITH_CARRY && FLAGS_IN.cy);
        calc.acc = sum[7:0];
        calc.flags.cy = sum[8];
        calc.flags.ac = nib[4];
        calc.flags.ov = (INSTR_IN.acc[7] == opnd[7]) && (sum[7] != opnd[7]);
      end
      alx_pkg::ALX_OP_SUBTRACT_WITH_BORROW: begin
        // Borrow taken from carry flag
        sum = 9'(INSTR_IN.acc) - 9'(opnd) - 9'(FLAGS_IN.cy);
        nib = 5'(INSTR_IN.acc[3:0]) - 5'(opnd[3:0]) - 5'(FLAGS_IN.cy);
        calc.acc = sum[7:0];
        calc.flags.cy = sum[8];
        calc.flags.ac = nib[4];
        calc.flags.ov = (INSTR_IN.acc[7] != opnd[7]) && (sum[7] != INSTR_IN.acc[7]);
      end
      alx_pkg::ALX_OP_AND, alx_pkg::ALX_OP_OR, alx_pkg::ALX_OP_XOR: begin
        // Direct destination forms combine with the current direct byte
        if (INSTR_IN.form == alx_pkg::ALX_DST_DIR_ACC ||
            INSTR_IN.form == alx_pkg::ALX_DST_DIR_IMM) begin
          src = INSTR_IN.dir_data;
          opnd = (INSTR_IN.form == alx_pkg::ALX_DST_DIR_ACC) ? INSTR_IN.acc : INSTR_IN.operand;
          calc.dir_we = 1'b1;
          if (INSTR_IN.form == alx_pkg::ALX_DST_DIR_IMM) begin
            calc.length = alx_pkg::LEN_THREE;
            calc.mcycles = alx_pkg::MC_TWO;
          end else begin
            calc.length = alx_pkg::LEN_TWO;
          end
        end
        if (INSTR_IN.op == alx_pkg::ALX_OP_AND) begin
          sum = 9'(src & opnd);
        end else if (INSTR_IN.op == alx_pkg::ALX_OP_OR) begin
          sum = 9'(src | opnd);
        end else begin
          sum = 9'(src ^ opnd);
        end
        if (calc.dir_we) begin
          calc.dir_data = sum[7:0];
        end else begin
          calc.acc = sum[7:0];
        end
      end
      alx_pkg::ALX_OP_SWAP: begin
        calc.acc = {INSTR_IN.acc[3:0], INSTR_IN.acc[7:4]};
        calc.length = alx_pkg::LEN_ONE;
      end
      alx_pkg::ALX_OP_RLC: begin
        calc.acc = {INSTR_IN.acc[6:0], FLAGS_IN.cy};
        calc.flags.cy = INSTR_IN.acc[7];
        calc.length = alx_pkg::LEN_ONE;
      end
      alx_pkg::ALX_OP_RRC: begin
        calc.acc = {FLAGS_IN.cy, INSTR_IN.acc[7:1]};
        calc.flags.cy = INSTR_IN.acc[0];
        calc.length = alx_pkg::LEN_ONE;
      end
      alx_pkg::ALX_OP_MUL: begin
        // Product low byte to accumulator, high to B
        prod = 16'(INSTR_IN.acc) * 16'(INSTR_IN.b_reg);
        calc.acc = prod[7:0];
        calc.b_reg = prod[15:8];
        calc.flags.cy = 1'b0;
        calc.flags.ov = (prod[15:8] != 8'h00);
        calc.length = alx_pkg::LEN_ONE;
        calc.mcycles = alx_pkg::MC_FOUR;
      end
      alx_pkg::ALX_OP_DIV: begin
        // Divide by zero leaves operands and sets overflow
        calc.flags.cy = 1'b0;
        calc.flags.ov = (INSTR_IN.b_reg == 8'h00);
        if (INSTR_IN.b_reg != 8'h00) begin
          calc.acc = INSTR_IN.acc / INSTR_IN.b_reg;
          calc.b_reg = INSTR_IN.acc % INSTR_IN.b_reg;
        end
        calc.length = alx_pkg::LEN_ONE;
        calc.mcycles = alx_pkg::MC_FOUR;
      end
      alx_pkg::ALX_OP_INC_DP: begin
        calc.data_pointer_16 = INSTR_IN.data_pointer_16 + 16'h0001;
        calc.length = alx_pkg::LEN_ONE;
        calc.mcycles = alx_pkg::MC_TWO;
      end
      default: begin
        calc.mcycles = alx_pkg::MC_ONE;
      end
    endcase
    // Parity tracks the resulting accumulator
    calc.flags.p = ^calc.acc;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Result is held back until the instruction's machine cycles have elapsed
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.stretch = stretch;
    unique case (st_reg.fsm)
      ALX_IDLE: begin
        if (ISSUE_IN) begin
          st_next.pend = calc;
          st_next.left = calc.mcycles;
          st_next.fsm = ALX_RUN;
        end
      end
      ALX_RUN: begin
        if (tick) begin
          st_next.left = st_reg.left - 3'h1;
          if (st_reg.left == 3'h1) begin
            st_next.res = st_reg.pend;
            st_next.done = 1'b1;
            st_next.fsm = ALX_DONE;
          end
        end
      end
      ALX_DONE: begin
        st_next.fsm = ALX_IDLE;
      end
      default: begin
        st_next.fsm = ALX_IDLE;
      end
    endcase
    // Busy kept as a flop so the output carries no decode glitch
    st_next.busy = (st_next.fsm != ALX_IDLE);
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_reg <= '{fsm: ALX_IDLE, res: '0, pend: '0, left: 3'h0, done: 1'b0, busy: 1'b0,
                  stretch: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign BUSY_OUT = st_reg.busy;
  assign DONE_OUT = st_reg.done;
  assign STRETCH_OUT = st_reg.stretch;
  assign RESULT_OUT = st_reg.res;

  // ****************************************
  // Checks
  // ****************************************
  a_done_tick: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (st_reg.fsm == ALX_RUN && tick && st_reg.left == 3'h1) |=> DONE_OUT)
    else $error("Done missing after final tick");
  a_swap_nib: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ISSUE_IN && !BUSY_OUT && INSTR_IN.op == alx_pkg::ALX_OP_SWAP) |=>
    (st_reg.pend.acc == {$past(INSTR_IN.acc[3:0]), $past(INSTR_IN.acc[7:4])}))
    else $error("Swap result wrong");
  a_rlc_carry: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ISSUE_IN && !BUSY_OUT && INSTR_IN.op == alx_pkg::ALX_OP_RLC) |=>
    (st_reg.pend.flags.cy == $past(INSTR_IN.acc[7]))
    && (st_reg.pend.acc[0] == $past(FLAGS_IN.cy)))
    else $error("Rotate left carry wrong");
  a_rrc_carry: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ISSUE_IN && !BUSY_OUT && INSTR_IN.op == alx_pkg::ALX_OP_RRC) |=>
    (st_reg.pend.flags.cy == $past(INSTR_IN.acc[0]))
    && (st_reg.pend.acc[7] == $past(FLAGS_IN.cy)))
    else $error("Rotate right carry wrong");
  a_muldiv_four: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ISSUE_IN && !BUSY_OUT && (INSTR_IN.op == alx_pkg::ALX_OP_MUL ||
     INSTR_IN.op == alx_pkg::ALX_OP_DIV)) |=> (st_reg.left == 3'h4))
    else $error("Multiply or divide not four cycles");
  a_dir_imm_len: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ISSUE_IN && !BUSY_OUT && INSTR_IN.form == alx_pkg::ALX_DST_DIR_IMM &&
     (INSTR_IN.op == alx_pkg::ALX_OP_AND || INSTR_IN.op == alx_pkg::ALX_OP_OR ||
      INSTR_IN.op == alx_pkg::ALX_OP_XOR)) |=>
    (st_reg.pend.length == 2'h3 && st_reg.left == 3'h2 && st_reg.pend.dir_we))
    else $error("Direct immediate logic form wrong");
  a_add_one: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ISSUE_IN && !BUSY_OUT && INSTR_IN.op == alx_pkg::ALX_OP_ADD) |=>
    (st_reg.left == 3'h1 &&
     st_reg.pend.acc == 8'($past(INSTR_IN.acc) + $past(INSTR_IN.operand))))
    else $error("Add result or timing wrong");
  a_subtract_with_borrow_val: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ISSUE_IN && !BUSY_OUT && INSTR_IN.op == alx_pkg::ALX_OP_SUBTRACT_WITH_BORROW) |=>
    (st_reg.pend.acc == 8'($past(INSTR_IN.acc) - $past(INSTR_IN.operand)
     - 8'($past(FLAGS_IN.cy)))))
    else $error("Subtract with borrow wrong");

endmodule
`default_nettype wire

// >>> dv/alx_exec_test.sv
// Self-checking testbench for the arithmetic and logical execution unit
`timescale 1ns/100ps
`default_nettype none
module alx_exec_test;
  // ****************************************
  // Stimulus, observed outputs and counters
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] wait_st = 2'h0;
  logic [2:0] clk_div = 3'h0;
  logic pfq_stall = 1'b0;
  logic bc_miss = 1'b0;
  logic issue = 1'b0;
  alx_pkg::alx_instr_s instr = '0;
  alx_pkg::alx_flags_s flags = '0;
  logic busy;
  logic done;
  logic stretch;
  alx_pkg::alx_result_s res;
  int n_mismatch = 0;
  int checked = 0;

  // Clock at 100 MHz
  always #5 sys_clk = ~sys_clk;

  alx_exec DUT (
    .SYS_CLK_IN(sys_clk),
    .RST_IN(rst),
    .WAIT_STATES_IN(wait_st),
    .CLK_DIV_IN(clk_div),
    .PFQ_STALL_IN(pfq_stall),
    .BC_MISS_IN(bc_miss),
    .ISSUE_IN(issue),
    .INSTR_IN(instr),
    .FLAGS_IN(flags),
    .BUSY_OUT(busy),
    .DONE_OUT(done),
    .STRETCH_OUT(stretch),
    .RESULT_OUT(res)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  // Compare with case inequality so an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reference result worked out from the instruction semantics
  function automatic alx_pkg::alx_result_s model(input alx_pkg::alx_instr_s i, input logic cy);
    alx_pkg::alx_result_s r;
    logic [8:0] s;
    logic [15:0] m;
    logic [7:0] t;
    logic [7:0] w;
    logic dir;
    r = '0;
    r.acc = i.acc;
    r.b_reg = i.b_reg;
    r.data_pointer_16 = i.data_pointer_16;
    r.flags.cy = cy;
    r.length = alx_pkg::LEN_ONE;
    r.mcycles = alx_pkg::MC_ONE;
    dir = (i.form == alx_pkg::ALX_DST_DIR_ACC) || (i.form == alx_pkg::ALX_DST_DIR_IMM);
    if (i.op <= alx_pkg::ALX_OP_XOR && i.form != alx_pkg::ALX_SRC_REG
        && i.form != alx_pkg::ALX_SRC_IND) begin
      r.length = (i.form == alx_pkg::ALX_DST_DIR_IMM) ? alx_pkg::LEN_THREE : alx_pkg::LEN_TWO;
    end
    if (i.form == alx_pkg::ALX_DST_DIR_IMM) begin
      r.mcycles = alx_pkg::MC_TWO;
    end
    case (i.op)
      alx_pkg::ALX_OP_ADD, alx_pkg::ALX_OP_ADD_WITH_CARRY: begin
        s = {1'b0, i.acc} + {1'b0, i.operand} + {8'h0, cy & (i.op == alx_pkg::ALX_OP_ADD_WITH_CARRY)};
        {r.flags.cy, r.acc} = s;
        r.flags.ac = ({1'b0, i.acc[3:0]} + {1'b0, i.operand[3:0]}
                      + {4'h0, cy & (i.op == alx_pkg::ALX_OP_ADD_WITH_CARRY)}) > 5'h0f;
        r.flags.ov = (i.acc[7] == i.operand[7]) && (s[7] != i.acc[7]);
      end
      alx_pkg::ALX_OP_SUBTRACT_WITH_BORROW: begin
        s = {1'b0, i.acc} - {1'b0, i.operand} - {8'h0, cy};
        {r.flags.cy, r.acc} = s;
        r.flags.ac = {1'b0, i.acc[3:0]} < ({1'b0, i.operand[3:0]} + {4'h0, cy});
        r.flags.ov = (i.acc[7] != i.operand[7]) && (s[7] != i.acc[7]);
      end
      alx_pkg::ALX_OP_AND, alx_pkg::ALX_OP_OR, alx_pkg::ALX_OP_XOR: begin
        t = dir ? i.dir_data : i.acc;
        w = (i.form == alx_pkg::ALX_DST_DIR_ACC) ? i.acc : i.operand;
        w = (i.op == alx_pkg::ALX_OP_AND) ? (t & w) : (i.op == alx_pkg::ALX_OP_OR) ? (t | w) : (t ^ w);
        r.dir_we = dir;
        if (dir) begin
          r.dir_data = w;
        end else begin
          r.acc = w;
        end
      end
      alx_pkg::ALX_OP_SWAP: r.acc = {i.acc[3:0], i.acc[7:4]};
      alx_pkg::ALX_OP_RLC: {r.flags.cy, r.acc} = {i.acc, cy};
      alx_pkg::ALX_OP_RRC: {r.acc, r.flags.cy} = {cy, i.acc};
      alx_pkg::ALX_OP_MUL: begin
        m = 16'(i.acc) * 16'(i.b_reg);
        {r.b_reg, r.acc} = m;
        r.flags.cy = 1'b0;
        r.flags.ov = (m[15:8] != 8'h00);
        r.mcycles = alx_pkg::MC_FOUR;
      end
      alx_pkg::ALX_OP_DIV: begin
        r.flags.cy = 1'b0;
        r.flags.ov = (i.b_reg == 8'h00);
        if (i.b_reg != 8'h00) begin
          r.acc = i.acc / i.b_reg;
          r.b_reg = i.acc % i.b_reg;
        end
        r.mcycles = alx_pkg::MC_FOUR;
      end
      default: begin
        r.data_pointer_16 = i.data_pointer_16 + 16'h1;
        r.mcycles = alx_pkg::MC_TWO;
      end
    endcase
    r.flags.p = ^r.acc;
    return r;
  endfunction

  // Issue one instruction, optionally with a stall held for hold cycles, and judge it
  task automatic run(input alx_pkg::alx_op_e op, input alx_pkg::alx_form_e form,
                     input logic [7:0] a, input logic [7:0] opd, input logic [7:0] b,
                     input logic cy, input int hold = 0, input logic on_bc = 1'b0);
    alx_pkg::alx_instr_s i;
    alx_pkg::alx_result_s e;
    int cyc;
    int native;
    logic seen_stretch;
    i = '{op: op, form: form, acc: a, operand: opd, dir_data: 8'h5a, b_reg: b, data_pointer_16: {a, opd}};
    e = model(i, cy);
    native = (4 + int'(wait_st)) << clk_div;
    seen_stretch = 1'b0;
    cyc = 0;
    // Never issue while the unit is busy
    @(negedge sys_clk);
    while (busy !== 1'b0 && cyc < 50) begin
      @(negedge sys_clk);
      cyc++;
    end
    if (busy !== 1'b0) begin
      n_mismatch++;
      $display("[ERR] %0t unit stuck busy", $time);
      conclude();
    end
    @(posedge sys_clk);
    issue <= 1'b1;
    instr <= i;
    flags <= '{cy: cy, ac: 1'b0, ov: 1'b0, p: 1'b0};
    pfq_stall <= (hold > 0) && !on_bc;
    bc_miss <= (hold > 0) && on_bc;
    @(posedge sys_clk);
    issue <= 1'b0;
    cyc = 1;
    forever begin
      @(negedge sys_clk);
      if (stretch === 1'b1) begin
        seen_stretch = 1'b1;
      end
      if (done === 1'b1 || cyc >= 400) begin
        break;
      end
      @(posedge sys_clk);
      cyc++;
      if (cyc == hold) begin
        pfq_stall <= 1'b0;
        bc_miss <= 1'b0;
      end
    end
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t no completion", $time);
      conclude();
    end
    check(16'(res.length), 16'(e.length), "length");
    check(16'(res.mcycles), 16'(e.mcycles), "cycles");
    check(16'(res.dir_we), 16'(e.dir_we), "dir we");
    if (e.dir_we) begin
      check(16'(res.dir_data), 16'(e.dir_data), "dir data");
    end
    if (op == alx_pkg::ALX_OP_INC_DP) begin
      check(res.data_pointer_16, e.data_pointer_16, "data_pointer_16");
    end else begin
      check(16'(res.acc), 16'(e.acc), "acc");
      check(16'(res.flags.cy), 16'(e.flags.cy), "carry");
      check(16'(res.flags.p), 16'(e.flags.p), "parity");
    end
    if (op == alx_pkg::ALX_OP_MUL || op == alx_pkg::ALX_OP_DIV) begin
      check(16'(res.b_reg), 16'(e.b_reg), "b reg");
    end
    check(16'(res.flags.ov), 16'(e.flags.ov), "overflow");
    check(16'(res.flags.ac), 16'(e.flags.ac), "aux carry");
    // Free-running timer: the first tick may come early, later ones every native length
    if (hold == 0) begin
      check(16'(cyc <= int'(e.mcycles) * native + 2), 16'h1, "late");
      check(16'(cyc >= (int'(e.mcycles) - 1) * native + 1), 16'h1, "early");
      check(16'(seen_stretch), 16'h0, "stretch idle");
    end else begin
      check(16'(cyc > hold), 16'h1, "stall held");
      check(16'(seen_stretch), 16'h1, "stretch");
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_arith();
    for (int f = 0; f < 4; f++) begin
      run(alx_pkg::ALX_OP_ADD, alx_pkg::alx_form_e'(3'(f)), 8'hf0, 8'h20, 8'h00, 1'b1);
    end
    run(alx_pkg::ALX_OP_ADD_WITH_CARRY, alx_pkg::ALX_SRC_IMM, 8'hff, 8'h00, 8'h00, 1'b1);
    run(alx_pkg::ALX_OP_ADD_WITH_CARRY, alx_pkg::ALX_SRC_REG, 8'h12, 8'h34, 8'h00, 1'b1);
    run(alx_pkg::ALX_OP_SUBTRACT_WITH_BORROW, alx_pkg::ALX_SRC_DIR, 8'h10, 8'h20, 8'h00, 1'b1);
    run(alx_pkg::ALX_OP_SUBTRACT_WITH_BORROW, alx_pkg::ALX_SRC_IND, 8'h80, 8'h01, 8'h00, 1'b0);
  endtask

  // Every logical operation in every operand form
  task automatic t_logic();
    for (int o = 3; o < 6; o++) begin
      for (int f = 0; f < 6; f++) begin
        run(alx_pkg::alx_op_e'(5'(o)), alx_pkg::alx_form_e'(3'(f)), 8'hc3, 8'h96, 8'h00,
            1'b1);
      end
    end
  endtask

  task automatic t_shift();
    run(alx_pkg::ALX_OP_SWAP, alx_pkg::ALX_SRC_REG, 8'ha5, 8'h00, 8'h00, 1'b1);
    run(alx_pkg::ALX_OP_RLC, alx_pkg::ALX_SRC_REG, 8'h81, 8'h00, 8'h00, 1'b0);
    run(alx_pkg::ALX_OP_RLC, alx_pkg::ALX_SRC_REG, 8'h01, 8'h00, 8'h00, 1'b1);
    run(alx_pkg::ALX_OP_RRC, alx_pkg::ALX_SRC_REG, 8'h81, 8'h00, 8'h00, 1'b0);
    run(alx_pkg::ALX_OP_RRC, alx_pkg::ALX_SRC_REG, 8'h80, 8'h00, 8'h00, 1'b1);
  endtask

  // Multi-cycle operations, including divide by zero and pointer wrap
  task automatic t_long();
    run(alx_pkg::ALX_OP_MUL, alx_pkg::ALX_SRC_REG, 8'h10, 8'h00, 8'h20, 1'b1);
    run(alx_pkg::ALX_OP_DIV, alx_pkg::ALX_SRC_REG, 8'hfb, 8'h00, 8'h10, 1'b1);
    run(alx_pkg::ALX_OP_DIV, alx_pkg::ALX_SRC_REG, 8'h33, 8'h00, 8'h00, 1'b0);
    run(alx_pkg::ALX_OP_INC_DP, alx_pkg::ALX_SRC_REG, 8'hff, 8'hff, 8'h00, 1'b0);
  endtask

  // Stalls from either source hold the machine cycle end
  task automatic t_stall();
    run(alx_pkg::ALX_OP_ADD, alx_pkg::ALX_SRC_REG, 8'h01, 8'h02, 8'h00, 1'b0, 25);
    run(alx_pkg::ALX_OP_MUL, alx_pkg::ALX_SRC_REG, 8'h07, 8'h00, 8'h09, 1'b0, 30,
        1'b1);
  endtask

  // Wait states and divider lengthen the native machine cycle
  task automatic t_slow();
    @(posedge sys_clk);
    wait_st <= 2'h1;
    clk_div <= 3'h1;
    repeat (30) @(posedge sys_clk);
    run(alx_pkg::ALX_OP_MUL, alx_pkg::ALX_SRC_REG, 8'hff, 8'h00, 8'hff, 1'b0);
    run(alx_pkg::ALX_OP_AND, alx_pkg::ALX_DST_DIR_IMM, 8'h0f, 8'h3c, 8'h00, 1'b0);
    @(posedge sys_clk);
    wait_st <= 2'h0;
    clk_div <= 3'h0;
    repeat (30) @(posedge sys_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_arith();
    t_logic();
    t_shift();
    t_long();
    t_stall();
    t_slow();
    conclude();
  end
endmodule
`default_nettype wire
